// >>> design/nvac_ctrl.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////
// How it works
// - program_permit clear blocks every write launch.
// - Setting program_cycle_go starts a write; hardware clears it at end.
// - program_cycle_go set without prior permit is ignored.
// - fetch_permit clear blocks every read launch.
// - Setting fetch_cycle_go starts a read; hardware clears it at end.
// - fetch_cycle_go set without prior permit is ignored.
// - Power-on clears all four control bits.
// - Read: load address, set permit, set go; data appears after clear.
// - Read data holds until the next read or a direct write to the data register; a write cycle leaves it.
// - Write cycle timed by an independent slow timer.
// - Write end raises done request; vectors if enables allow and stack not full.
// - Servicing clears done request and global enable.
// - Pointer high bytes reset to zero, hiding the control register.
// - Control bits 7 to 4 read zero.
// - Array holds 32 bytes, 5-bit address, 8-bit data.
// - Control register sits at 40H of sector 1, indirect only.
module nvac_ctrl #(
  parameter int WRITE_CYCLES = nvac_pkg::WRITE_CYCLES,
  parameter int READ_CYCLES = nvac_pkg::READ_CYCLES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Direct register port
  input wire logic wr_en_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [7:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  // Indirect port through pointer pair
  input wire logic ind_wr_en_i,
  input wire logic [7:0] ind_wr_data_i,
  input wire logic [7:0] ind_low_i,
  input wire logic ind_sel2_i,
  output logic [7:0] ind_rd_data_o,
  // Interrupt side
  input wire logic nv_irq_enable_i,
  input wire logic global_irq_enable_i,
  input wire logic stack_full_i,
  input wire logic irq_ack_i,
  output logic nv_done_request_o,
  output logic irq_vector_o,
  output logic global_irq_clear_o,
  // Status
  output logic busy_o
);
  ////////////////////////////////////////////////////////////////////////
  logic [nvac_pkg::ADDR_W-1:0] addr_ff;
  logic [nvac_pkg::DATA_W-1:0] data_ff;
  logic [3:0] ctrl_ff;
  logic [7:0] ptr1_hi_ff;
  logic [7:0] ptr2_hi_ff;
  logic done_ff;
  logic [nvac_pkg::CNT_W-1:0] cnt_ff;
  logic [nvac_pkg::DATA_W-1:0] mem_ff [nvac_pkg::DEPTH];
  nvac_pkg::nvac_state_type state_ff;
  logic tick_w;

  nvac_timer i_nvac_timer (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .tick_o(tick_w)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decode
  wire [7:0] hi_w = ind_sel2_i ? ptr2_hi_ff : ptr1_hi_ff;
  wire ctrl_hit_w = (hi_w == nvac_pkg::CTRL_SECTOR) &&
                    (ind_low_i == nvac_pkg::CTRL_REG_OFS);
  wire ctrl_wr_w = ind_wr_en_i && ctrl_hit_w;
  wire idle_w = (state_ff == nvac_pkg::ST_IDLE);
  wire [3:0] wv_w = ind_wr_data_i[3:0];
  // Launch needs permit already stored, not in the same write
  wire prog_go_w = ctrl_wr_w && idle_w && wv_w[nvac_pkg::PROG_GO_BIT]
                   && ctrl_ff[nvac_pkg::PROG_PERMIT_BIT];
  wire fetch_go_w = ctrl_wr_w && idle_w && !prog_go_w
                    && wv_w[nvac_pkg::FETCH_GO_BIT]
                    && ctrl_ff[nvac_pkg::FETCH_PERMIT_BIT];
  wire cnt_zero_w = (cnt_ff == '0);
  wire rd_end_w = (state_ff == nvac_pkg::ST_READ) && cnt_zero_w;
  wire wr_end_w = (state_ff == nvac_pkg::ST_WRITE) && cnt_zero_w && tick_w;
  wire addr_wr_w = wr_en_i && (wr_addr_i == nvac_pkg::ADDR_REG_OFS);
  wire data_wr_w = wr_en_i && (wr_addr_i == nvac_pkg::DATA_REG_OFS);
  wire ptr_wr_w = wr_en_i && (wr_addr_i == nvac_pkg::PTR_HI_OFS);

  ////////////////////////////////////////////////////////////////////////
  // Next control value; go bits only set by a valid launch
  logic [3:0] nxt_ctrl;
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (ctrl_wr_w) begin
      nxt_ctrl[nvac_pkg::PROG_PERMIT_BIT] = wv_w[nvac_pkg::PROG_PERMIT_BIT];
      nxt_ctrl[nvac_pkg::FETCH_PERMIT_BIT] =
        wv_w[nvac_pkg::FETCH_PERMIT_BIT];
      if (!wv_w[nvac_pkg::PROG_GO_BIT] && !idle_w) begin
        nxt_ctrl[nvac_pkg::PROG_GO_BIT] = ctrl_ff[nvac_pkg::PROG_GO_BIT];
      end
    end
    if (prog_go_w) begin
      nxt_ctrl[nvac_pkg::PROG_GO_BIT] = 1'b1;
    end
    if (fetch_go_w) begin
      nxt_ctrl[nvac_pkg::FETCH_GO_BIT] = 1'b1;
    end
    if (wr_end_w) begin
      nxt_ctrl[nvac_pkg::PROG_GO_BIT] = 1'b0;
    end
    if (rd_end_w) begin
      nxt_ctrl[nvac_pkg::FETCH_GO_BIT] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_ff <= nvac_pkg::ST_IDLE;
      cnt_ff <= '0;
    end else begin
      unique case (state_ff)
        nvac_pkg::ST_IDLE: begin
          if (prog_go_w) begin
            state_ff <= nvac_pkg::ST_WRITE;
            cnt_ff <= nvac_pkg::CNT_W'(WRITE_CYCLES - 1);
          end else if (fetch_go_w) begin
            state_ff <= nvac_pkg::ST_READ;
            cnt_ff <= nvac_pkg::CNT_W'(READ_CYCLES - 1);
          end
        end
        nvac_pkg::ST_READ: begin
          if (cnt_zero_w) begin
            state_ff <= nvac_pkg::ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff - nvac_pkg::CNT_W'(1);
          end
        end
        nvac_pkg::ST_WRITE: begin
          if (tick_w) begin
            if (cnt_zero_w) begin
              state_ff <= nvac_pkg::ST_IDLE;
            end else begin
              cnt_ff <= cnt_ff - nvac_pkg::CNT_W'(1);
            end
          end
        end
        default: begin
          state_ff <= nvac_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctrl_ff <= nvac_pkg::CTRL_RESET;
      addr_ff <= '0;
      data_ff <= nvac_pkg::BYTE_RESET;
      ptr1_hi_ff <= nvac_pkg::BYTE_RESET;
      ptr2_hi_ff <= nvac_pkg::BYTE_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
      if (addr_wr_w) begin
        addr_ff <= wr_data_i[nvac_pkg::ADDR_W-1:0];
      end
      if (rd_end_w) begin
        data_ff <= mem_ff[addr_ff];
      end else if (data_wr_w) begin
        data_ff <= wr_data_i;
      end
      if (ptr_wr_w) begin
        if (ind_sel2_i) begin
          ptr2_hi_ff <= wr_data_i;
        end else begin
          ptr1_hi_ff <= wr_data_i;
        end
      end
    end
  end

  // Array, written at end of write cycle
  always_ff @(posedge clock_i) begin
    if (wr_end_w) begin
      mem_ff[addr_ff] <= data_ff;
    end
  end

  // Done request: set wins over service clear
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      done_ff <= 1'b0;
    end else if (wr_end_w) begin
      done_ff <= 1'b1;
    end else if (irq_ack_i) begin
      done_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Readback
  assign rd_data_o = (rd_addr_i == nvac_pkg::ADDR_REG_OFS) ?
                     {3'h0, addr_ff} :
                     (rd_addr_i == nvac_pkg::DATA_REG_OFS) ? data_ff :
                     (rd_addr_i == nvac_pkg::PTR_HI_OFS) ?
                     (ind_sel2_i ? ptr2_hi_ff : ptr1_hi_ff) : 8'h00;
  assign ind_rd_data_o = ctrl_hit_w ? {4'h0, ctrl_ff} : 8'h00;
  assign nv_done_request_o = done_ff;
  assign irq_vector_o = done_ff && nv_irq_enable_i && global_irq_enable_i
                        && !stack_full_i;
  assign global_irq_clear_o = irq_ack_i;
  assign busy_o = !idle_w;
endmodule // nvac_ctrl
`default_nettype wire

// >>> design/nvac_pkg.sv
`default_nettype none
package nvac_pkg;
  // Special function register addresses
  localparam logic [7:0] ADDR_REG_OFS = 8'h00;
  localparam logic [7:0] DATA_REG_OFS = 8'h01;
  localparam logic [7:0] CTRL_REG_OFS = 8'h40;
  localparam logic [7:0] PTR_HI_OFS = 8'h02;
  localparam logic [7:0] CTRL_SECTOR = 8'h01;
  // Control fields
  localparam int FETCH_GO_BIT = 0;
  localparam int FETCH_PERMIT_BIT = 1;
  localparam int PROG_GO_BIT = 2;
  localparam int PROG_PERMIT_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // Array geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int DEPTH = 32;
  // Cycle timing
  localparam int WRITE_CYCLES = 64;
  localparam int READ_CYCLES = 2;
  localparam int TIMER_DIV = 8;
  localparam int CNT_W = 16;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } nvac_state_type;
endpackage
`default_nettype wire

// >>> design/nvac_timer.sv
`default_nettype none
// Free-running slow tick standing in for the asynchronous write timer
module nvac_timer (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Tick out
  output logic tick_o
);
  localparam int CW = 8;
  logic [CW-1:0] cnt_ff;
  wire last_w = (cnt_ff == CW'(nvac_pkg::TIMER_DIV - 1));
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= last_w ? '0 : cnt_ff + CW'(1);
    end
  end
  assign tick_o = last_w;
endmodule // nvac_timer
`default_nettype wire

// >>> verif/nvac_ctrl_properties.sv
`default_nettype none
module nvac_ctrl_chk #(
  parameter int WRITE_CYCLES = nvac_pkg::WRITE_CYCLES,
  parameter int READ_CYCLES = nvac_pkg::READ_CYCLES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic ind_wr_en_i,
  input wire logic [7:0] ind_wr_data_i,
  input wire logic [7:0] ind_rd_data_o,
  input wire logic nv_irq_enable_i,
  input wire logic global_irq_enable_i,
  input wire logic stack_full_i,
  input wire logic irq_ack_i,
  input wire logic nv_done_request_o,
  input wire logic irq_vector_o,
  input wire logic global_irq_clear_o,
  input wire logic busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RHI = READ_CYCLES + 1;
  localparam int WLO = (WRITE_CYCLES - 1) * nvac_pkg::TIMER_DIV;
  localparam int WHI = WRITE_CYCLES * nvac_pkg::TIMER_DIV + 2;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  a_high_zero: assert property (
    ind_rd_data_o[7:4] == 4'h0) else $error("upper control bits set");
  a_go_source: assert property (
    $rose(busy_o) |-> $past(ind_wr_en_i)) else $error("busy without write");
  a_read_length: assert property (
    $rose(busy_o) && $past(ind_wr_data_i[0]) |-> ##[READ_CYCLES:RHI]
    ($fell(busy_o) && !$rose(nv_done_request_o))) else $error("read end");
  a_write_timer: assert property (
    $rose(busy_o) && $past(ind_wr_data_i[2]) |-> ##[WLO:WHI]
    ($fell(busy_o) && nv_done_request_o)) else $error("write end");
  a_done_holds: assert property (
    nv_done_request_o && !irq_ack_i |=> nv_done_request_o)
    else $error("done dropped");
  a_ack_clears: assert property (
    irq_ack_i && !busy_o |=> !nv_done_request_o) else $error("done kept");
  a_vector_gate: assert property (
    irq_vector_o == (nv_done_request_o && nv_irq_enable_i &&
    global_irq_enable_i && !stack_full_i)) else $error("vector wrong");
  a_global_clear: assert property (
    global_irq_clear_o == irq_ack_i) else $error("global clear wrong");
endmodule // nvac_ctrl_chk
bind nvac_ctrl nvac_ctrl_chk #(
  .WRITE_CYCLES(WRITE_CYCLES), .READ_CYCLES(READ_CYCLES)
) i_nvac_ctrl_chk (
  .clock_i(clock_i), .rst_i(rst_i), .ind_wr_en_i(ind_wr_en_i),
  .ind_wr_data_i(ind_wr_data_i), .ind_rd_data_o(ind_rd_data_o),
  .nv_irq_enable_i(nv_irq_enable_i),
  .global_irq_enable_i(global_irq_enable_i),
  .stack_full_i(stack_full_i), .irq_ack_i(irq_ack_i),
  .nv_done_request_o(nv_done_request_o), .irq_vector_o(irq_vector_o),
  .global_irq_clear_o(global_irq_clear_o), .busy_o(busy_o)
);
`default_nettype wire

// >>> verif/nvac_cpu.sv
`default_nettype none
module nvac_cpu (
  // Clock
  input wire logic clock_i,
  // Register access
  output var logic wr_en_o,
  output var logic ind_wr_en_o,
  output var logic [7:0] wr_addr_o,
  output var logic [7:0] wr_data_o,
  output var logic [7:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  input wire logic [7:0] ind_rd_data_i
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {wr_en_o, ind_wr_en_o} = 2'h0;
    {wr_addr_o, wr_data_o, rd_addr_o} = 24'h0;
  end
  // One write at a time, held to its taking edge
  task automatic put(input logic ind, input logic [7:0] a,
    input logic [7:0] v);
    @(posedge clock_i);
    {ind_wr_en_o, wr_en_o} <= {ind, ~ind};
    wr_addr_o <= a;
    wr_data_o <= v;
    @(posedge clock_i);
    {ind_wr_en_o, wr_en_o} <= 2'h0;
    wr_data_o <= ~v; // Released bus shows no stale value
  endtask
  task automatic get(input logic ind, input logic [7:0] a,
    output logic [7:0] d);
    @(posedge clock_i);
    rd_addr_o <= a;
    #1 d = ind ? ind_rd_data_i : rd_data_i;
  endtask
endmodule // nvac_cpu
`default_nettype wire

// >>> verif/tb_nvac_ctrl.sv
`default_nettype none
module tb_nvac_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i = 1'h0;
  logic rst_i = 1'h1;
  logic nv_irq_enable_i = 1'h0;
  logic global_irq_enable_i = 1'h0;
  logic stack_full_i = 1'h0;
  logic irq_ack_i = 1'h0;
  logic ind_sel2_i = 1'h0;
  logic [7:0] ind_low_i = 8'h40;
  wire logic wr_en_i, ind_wr_en_i, nv_done_request_o;
  wire logic irq_vector_o, global_irq_clear_o, busy_o;
  wire logic [7:0] wr_addr_i, wr_data_i, rd_addr_i, rd_data_o;
  wire logic [7:0] ind_rd_data_o;
  wire logic [7:0] ind_wr_data_i = wr_data_i;
  logic [7:0] d;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  initial forever #2 clock_i = ~clock_i;
  nvac_ctrl #(.WRITE_CYCLES(2)) i_nvac_ctrl (
    .clock_i(clock_i), .rst_i(rst_i), .wr_en_i(wr_en_i),
    .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .rd_addr_i(rd_addr_i),
    .rd_data_o(rd_data_o), .ind_wr_en_i(ind_wr_en_i),
    .ind_wr_data_i(ind_wr_data_i), .ind_low_i(ind_low_i),
    .ind_sel2_i(ind_sel2_i), .ind_rd_data_o(ind_rd_data_o),
    .nv_irq_enable_i(nv_irq_enable_i),
    .global_irq_enable_i(global_irq_enable_i),
    .stack_full_i(stack_full_i), .irq_ack_i(irq_ack_i),
    .nv_done_request_o(nv_done_request_o), .irq_vector_o(irq_vector_o),
    .global_irq_clear_o(global_irq_clear_o), .busy_o(busy_o)
  );
  nvac_cpu i_nvac_cpu (.clock_i(clock_i), .wr_en_o(wr_en_i),
    .ind_wr_en_o(ind_wr_en_i), .wr_addr_o(wr_addr_i), .wr_data_o(wr_data_i),
    .rd_addr_o(rd_addr_i), .rd_data_i(rd_data_o),
    .ind_rd_data_i(ind_rd_data_o));
  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic ctl(input logic w, input logic [7:0] v, input logic [7:0] e);
    if (w) begin
      i_nvac_cpu.put(1'h1, 8'h40, v);
    end
    i_nvac_cpu.get(1'h1, 8'h00, d);
    chk("control", e, d);
  endtask
  task automatic sfr(input logic [7:0] a, input logic [7:0] e);
    i_nvac_cpu.get(1'h0, a, d);
    chk("register", e, d);
  endtask
  task automatic irq(input logic [3:0] v);
    @(posedge clock_i);
    {nv_irq_enable_i, global_irq_enable_i, stack_full_i, irq_ack_i} <= v;
    #1;
  endtask
  task automatic idle;
    int n;
    n = 0;
    while (busy_o !== 1'h0 && n < 100) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    chk("busy", 8'h00, {7'h0, busy_o});
  endtask
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    repeat (5) @(posedge clock_i);
    rst_i <= 1'h0;
    sfr(8'h01, 8'h00);
    i_nvac_cpu.put(1'h0, 8'h02, 8'h01);
    ctl(1'h0, 8'h00, 8'h00);
    ctl(1'h1, 8'h04, 8'h00);
    ctl(1'h1, 8'h03, 8'h02);
    ctl(1'h1, 8'hF0, 8'h00);
    i_nvac_cpu.put(1'h0, 8'h00, 8'hFF);
    sfr(8'h00, 8'h1F);
    i_nvac_cpu.put(1'h0, 8'h00, 8'h05);
    i_nvac_cpu.put(1'h0, 8'h01, 8'hA5);
    ctl(1'h1, 8'h08, 8'h08);
    ctl(1'h1, 8'h0C, 8'h0C);
    chk("busy", 8'h01, {7'h0, busy_o});
    idle();
    ctl(1'h0, 8'h00, 8'h08);
    chk("done", 8'h01, {7'h0, nv_done_request_o});
    irq(4'hE);
    chk("vector", 8'h00, {7'h0, irq_vector_o});
    irq(4'hC);
    chk("vector", 8'h01, {7'h0, irq_vector_o});
    irq(4'hD);
    chk("clear", 8'h01, {7'h0, global_irq_clear_o});
    irq(4'h0);
    chk("done", 8'h00, {7'h0, nv_done_request_o});
    i_nvac_cpu.put(1'h0, 8'h01, 8'h00);
    i_nvac_cpu.put(1'h0, 8'h00, 8'h05);
    ctl(1'h1, 8'h02, 8'h02);
    ctl(1'h1, 8'h03, 8'h03);
    idle();
    ctl(1'h0, 8'h00, 8'h02);
    sfr(8'h01, 8'hA5);
    i_nvac_cpu.put(1'h0, 8'h00, 8'h06);
    sfr(8'h01, 8'hA5);
    @(posedge clock_i);
    ind_sel2_i <= 1'h1;
    ctl(1'h0, 8'h00, 8'h00);
    sfr(8'h02, 8'h00);
    i_nvac_cpu.put(1'h0, 8'h02, 8'h01);
    sfr(8'h02, 8'h01);
    ctl(1'h0, 8'h00, 8'h02);
    // Wrong pointer low byte: no access to control
    @(posedge clock_i);
    ind_low_i <= 8'h41;
    ctl(1'h1, 8'h0A, 8'h00);
    @(posedge clock_i);
    ind_low_i <= 8'h40;
    ctl(1'h0, 8'h00, 8'h02);
    // Reset in mid-run
    @(posedge clock_i);
    rst_i <= 1'h1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'h0;
    sfr(8'h02, 8'h00);
    i_nvac_cpu.put(1'h0, 8'h02, 8'h01);
    ctl(1'h0, 8'h00, 8'h00);
    conclude();
  end
endmodule // tb_nvac_ctrl
`default_nettype wire
